// ### rtl/ucr_channel_regs.sv
`timescale 1ns/100ps
`include "ucr_consts.svh"

module ucr_channel_regs (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Register access from the bridge
  input  wire ucr_pkg::ucr_bus_s   bus,
  output logic [7:0]               rdata,
  // Status from the channel datapath
  input  wire ucr_pkg::ucr_stat_s  stat,
  // Configuration to the channel datapath
  output ucr_pkg::ucr_rw_s         cfg,
  output ucr_pkg::ucr_wo_s         wcfg,
  output ucr_pkg::ucr_ctl_s        ctl
);

  ucr_pkg::ucr_state_s s_q;
  ucr_pkg::ucr_state_s s_d;

  logic       dlab;
  logic       enh;
  logic [7:0] rd_mux;

  assign dlab = s_q.rw.line_control[`UCR_LCR_DIVEN];
  assign enh  = s_q.rw.enhanced_function[`UCR_EFR_ENH];

  // Read multiplexer
  always_comb begin
    rd_mux = `UCR_RST_BYTE;
    unique case (bus.addr)
      `UCR_A_HOLD:    rd_mux = dlab ? s_q.rw.divisor_low
                                    : stat.rx_holding;
      `UCR_A_IER:     rd_mux = dlab ? s_q.rw.divisor_high
                                    : s_q.rw.interrupt_enable;
      `UCR_A_ISR: begin
        if (dlab) begin
          rd_mux = s_q.rw.divisor_fraction_modes;
        end else if (enh) begin
          rd_mux = stat.interrupt_status;
        end else begin
          rd_mux = stat.interrupt_status & ~`UCR_ISR_ENH;
        end
      end
      `UCR_A_LCR:     rd_mux = s_q.rw.line_control;
      `UCR_A_MCR:     rd_mux = s_q.rw.modem_control;
      `UCR_A_LSR:     rd_mux = stat.line_status;
      `UCR_A_MSR:     rd_mux = stat.modem_status;
      `UCR_A_SPR:     rd_mux = s_q.rw.scratch_pad;
      `UCR_A_FEATURE_CONTROL:    rd_mux = s_q.rw.feature_control;
      `UCR_A_EFR:     rd_mux = s_q.rw.enhanced_function;
      `UCR_A_TXLVL:   rd_mux = stat.tx_fifo_level;
      `UCR_A_RXLVL:   rd_mux = stat.rx_fifo_level;
      `UCR_A_PAUSE1:  rd_mux = {4'h0, s_q.flags};
      `UCR_A_PAUSE2,
      `UCR_A_RESUME1,
      `UCR_A_RESUME2: rd_mux = `UCR_RST_BYTE;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.wo.tx_load    = 1'b0;
    s_d.wo.rx_unload  = 1'b0;
    s_d.wo.fifo_write = 1'b0;
    if (bus.rd) begin
      s_d.rdata = rd_mux;
      if (!dlab && bus.addr == `UCR_A_HOLD) begin
        s_d.wo.rx_unload = 1'b1;
      end
    end
    // Set wins over the read clear so no event is lost
    if (bus.rd && bus.addr == `UCR_A_PAUSE1) begin
      s_d.flags = stat.flow_events;
    end else begin
      s_d.flags = s_q.flags | stat.flow_events;
    end
    if (bus.wr) begin
      unique case (bus.addr)
        `UCR_A_HOLD: begin
          if (dlab) begin
            s_d.rw.divisor_low = bus.wdata;
          end else begin
            s_d.wo.tx_holding = bus.wdata;
            s_d.wo.tx_load    = 1'b1;
          end
        end
        `UCR_A_IER: begin
          if (dlab) begin
            s_d.rw.divisor_high = bus.wdata;
          end else if (enh) begin
            s_d.rw.interrupt_enable = bus.wdata;
          end else begin
            s_d.rw.interrupt_enable =
              (s_q.rw.interrupt_enable & `UCR_IER_ENH) |
              (bus.wdata & ~`UCR_IER_ENH);
          end
        end
        `UCR_A_ISR: begin
          if (dlab) begin
            s_d.rw.divisor_fraction_modes = bus.wdata;
          end else begin
            // Gated bits keep their last enhanced value
            s_d.wo.fifo_control = enh ? bus.wdata :
              ((s_q.wo.fifo_control & `UCR_FCR_ENH) |
               (bus.wdata & ~`UCR_FCR_ENH));
            s_d.wo.fifo_write = 1'b1;
          end
        end
        `UCR_A_LCR:     s_d.rw.line_control = bus.wdata;
        `UCR_A_MCR: begin
          s_d.rw.modem_control = enh ? bus.wdata :
            ((s_q.rw.modem_control & `UCR_MCR_ENH) |
             (bus.wdata & ~`UCR_MCR_ENH));
        end
        `UCR_A_LSR:     s_d.rdata = s_q.rdata;
        `UCR_A_MSR: begin
          if (enh) begin
            s_d.wo.turnaround_delay_disables = bus.wdata;
          end
        end
        `UCR_A_SPR:     s_d.rw.scratch_pad = bus.wdata;
        `UCR_A_FEATURE_CONTROL:    s_d.rw.feature_control = bus.wdata;
        `UCR_A_EFR:     s_d.rw.enhanced_function = bus.wdata;
        `UCR_A_TXLVL:   s_d.wo.tx_fifo_threshold = bus.wdata;
        `UCR_A_RXLVL:   s_d.wo.rx_fifo_threshold = bus.wdata;
        `UCR_A_PAUSE1:  s_d.wo.pause_char_first = bus.wdata;
        `UCR_A_PAUSE2:  s_d.wo.pause_char_second = bus.wdata;
        `UCR_A_RESUME1: s_d.wo.resume_char_first = bus.wdata;
        `UCR_A_RESUME2: s_d.wo.resume_char_second = bus.wdata;
      endcase
    end
    // Decoded controls follow the registered state one cycle later
    s_d.ctl.enh_en         = enh;
    s_d.ctl.loopback       = s_q.rw.modem_control[`UCR_MCR_LOOP];
    // Bits 3:2 stay storage; only bit 2 feeds flow pair choice
    s_d.ctl.flow_pair_dtr  = s_q.rw.modem_control[`UCR_MCR_FSEL];
    // Auto flow bits are not among the enhanced-gated bits
    s_d.ctl.auto_cts       = s_q.rw.enhanced_function[`UCR_EFR_ACTS];
    s_d.ctl.auto_rts       = s_q.rw.enhanced_function[`UCR_EFR_ARTS];
    s_d.ctl.dir_active_low =
      s_q.rw.divisor_fraction_modes[`UCR_DLD_POL];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Mask follows the enable bit itself, not the lagging decoded copy,
  // so gated bits never leak for a cycle after the enable drops
  always_comb begin
    cfg = s_q.rw;
    if (!enh) begin
      cfg.interrupt_enable = s_q.rw.interrupt_enable & ~`UCR_IER_ENH;
      cfg.modem_control    = s_q.rw.modem_control & ~`UCR_MCR_ENH;
    end
    wcfg = s_q.wo;
    if (!enh) begin
      wcfg.fifo_control = s_q.wo.fifo_control & ~`UCR_FCR_ENH;
    end
  end

  assign rdata = s_q.rdata;
  assign ctl   = s_q.ctl;

endmodule

// ### rtl/ucr_consts.svh
`ifndef UCR_CONSTS_SVH
`define UCR_CONSTS_SVH

// Register addresses
`define UCR_A_HOLD     4'h0
`define UCR_A_IER      4'h1
`define UCR_A_ISR      4'h2
`define UCR_A_LCR      4'h3
`define UCR_A_MCR      4'h4
`define UCR_A_LSR      4'h5
`define UCR_A_MSR      4'h6
`define UCR_A_SPR      4'h7
`define UCR_A_FEATURE_CONTROL     4'h8
`define UCR_A_EFR      4'h9
`define UCR_A_TXLVL    4'hA
`define UCR_A_RXLVL    4'hB
`define UCR_A_PAUSE1   4'hC
`define UCR_A_PAUSE2   4'hD
`define UCR_A_RESUME1  4'hE
`define UCR_A_RESUME2  4'hF

// Field positions
`define UCR_LCR_DIVEN  7
`define UCR_EFR_ENH    4
`define UCR_EFR_ACTS   7
`define UCR_EFR_ARTS   6
`define UCR_MCR_LOOP   4
`define UCR_MCR_FSEL   2
`define UCR_DLD_POL    7

// Masks of bits gated by the enhanced enable, plus the ungated MCR spare storage bits
`define UCR_IER_ENH    8'hE0
`define UCR_FCR_ENH    8'h30
`define UCR_MCR_ENH    8'hE0
`define UCR_ISR_ENH    8'h30
`define UCR_MCR_SPARE  8'h0C

// Reset values
`define UCR_RST_BYTE   8'h00

`endif

// ### rtl/ucr_pkg.sv
package ucr_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ucr_bus_s;

  typedef struct packed {
    logic [7:0] rx_holding;
    logic [7:0] interrupt_status;
    logic [7:0] line_status;
    logic [7:0] modem_status;
    logic [7:0] tx_fifo_level;
    logic [7:0] rx_fifo_level;
    logic [3:0] flow_events;
  } ucr_stat_s;

  typedef struct packed {
    logic [7:0] tx_holding;
    logic       tx_load;
    logic       rx_unload;
    logic [7:0] fifo_control;
    logic       fifo_write;
    logic [7:0] turnaround_delay_disables;
    logic [7:0] tx_fifo_threshold;
    logic [7:0] rx_fifo_threshold;
    logic [7:0] pause_char_first;
    logic [7:0] pause_char_second;
    logic [7:0] resume_char_first;
    logic [7:0] resume_char_second;
  } ucr_wo_s;

  typedef struct packed {
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic [7:0] divisor_fraction_modes;
    logic [7:0] interrupt_enable;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] scratch_pad;
    logic [7:0] feature_control;
    logic [7:0] enhanced_function;
  } ucr_rw_s;

  typedef struct packed {
    logic loopback;
    logic flow_pair_dtr;
    logic auto_cts;
    logic auto_rts;
    logic dir_active_low;
    logic enh_en;
  } ucr_ctl_s;

  typedef struct packed {
    ucr_rw_s    rw;
    ucr_wo_s    wo;
    logic [3:0] flags;
    logic [7:0] rdata;
    ucr_ctl_s   ctl;
  } ucr_state_s;

endpackage

// ### testbench/ucr_bridge_model.sv
`timescale 1ns/100ps
module ucr_bridge_model (
  // Clock
  input wire logic          clk,
  // Register access toward the channel
  output ucr_pkg::ucr_bus_s bus,
  input wire logic [7:0]    rdata
);
  initial bus = '0;
  // One strobe cycle, then one idle cycle, so requests never merge
  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk) #1;
    bus = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk) #1;
    bus = '0;
    q = rdata;
  endtask
endmodule

// ### testbench/ucr_channel_regs_bench.sv
`timescale 1ns/100ps
module ucr_channel_regs_bench;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  ucr_pkg::ucr_bus_s  bus;
  ucr_pkg::ucr_stat_s stat = '0;
  ucr_pkg::ucr_rw_s   cfg;
  ucr_pkg::ucr_wo_s   wcfg;
  ucr_pkg::ucr_ctl_s  ctl;
  logic [7:0]         rdata, q, r;
  logic [31:0]        seed = 32'h3FC2F31E;
  int                 n_mismatch = 0, check_count = 0, cyc = 0;
  always #2.5 clk = ~clk;
  ucr_channel_regs DUT (.clk(clk), .rst_n(rst_n), .bus(bus),
    .rdata(rdata), .stat(stat), .cfg(cfg), .wcfg(wcfg), .ctl(ctl));
  ucr_bridge_model BRG (.clk(clk), .bus(bus), .rdata(rdata));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    BRG.acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    BRG.acc(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    stat = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), 4'h0};
    r = rnd();
    wr(4'h3, 8'h80);
    wr(4'h0, r);
    wr(4'h2, 8'h80);
    rd(4'h0, r);
    wr(4'h3, 8'h03);
    wr(4'h0, ~r);
    rd(4'h0, stat.rx_holding);
    wr(4'h3, 8'h80);
    rd(4'h0, r);
    wr(4'h3, 8'h03);
    wr(4'h1, 8'hEF);
    rd(4'h1, 8'h0F);
    rd(4'h2, stat.interrupt_status & 8'hCF);
    wr(4'h9, 8'hD0);
    wr(4'h1, 8'hEF);
    rd(4'h1, 8'hEF);
    rd(4'h2, stat.interrupt_status);
    wr(4'h4, 8'h1C);
    rd(4'h4, 8'h1C);
    chk({2'b00, ctl}, 8'h3F);
    // Events land before the first read of each pair, so the second read sees them cleared
    repeat (6) begin
      r = rnd();
      @(posedge clk) #1 stat.flow_events = r[3:0];
      @(posedge clk) #1 stat.flow_events = 4'h0;
      rd(4'hC, {4'h0, r[3:0]});
      rd(4'hC, 8'h00);
    end
    wr(4'h9, 8'h00);
    wr(4'h6, 8'h5A);
    chk(wcfg.turnaround_delay_disables, 8'h00);
    wr(4'h4, 8'hFF);
    rd(4'h4, 8'h1F);
    wr(4'h9, 8'h10);
    wr(4'h6, 8'h5A);
    chk(wcfg.turnaround_delay_disables, 8'h5A);
    rd(4'h7, 8'h00);
    r = rnd();
    wr(4'hC, r);
    chk(wcfg.pause_char_first, r);
    rd(4'hC, 8'h00);
    rd(4'h5, stat.line_status);
    rd(4'h6, stat.modem_status);
    chk({2'b00, ctl}, 8'h33);
    complete_run();
  end
endmodule
bind ucr_channel_regs ucr_regs_chk CHK (.clk(clk), .rst_n(rst_n),
  .bus(bus), .rdata(rdata), .cfg(cfg), .wcfg(wcfg), .ctl(ctl));

// ### testbench/ucr_regs_chk.sv
`timescale 1ns/100ps
module ucr_regs_chk (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire ucr_pkg::ucr_bus_s bus,
  input wire logic [7:0]        rdata,
  input wire ucr_pkg::ucr_rw_s  cfg,
  input wire ucr_pkg::ucr_wo_s  wcfg,
  input wire ucr_pkg::ucr_ctl_s ctl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  enh_gate_a: assert property (!cfg.enhanced_function[4] |->
    !(cfg.interrupt_enable[7:5] | cfg.modem_control[7:5]))
    else $error("enhanced bits visible");
  msr_lock_a: assert property (bus.wr && bus.addr == 4'h6 &&
    !cfg.enhanced_function[4] |=> $stable(wcfg.turnaround_delay_disables))
    else $error("locked write took effect");
  flag_top_a: assert property (bus.rd && bus.addr == 4'hC |=>
    rdata[7:4] == 4'h0) else $error("flag read upper bits set");
  spare_keep_a: assert property (bus.wr && bus.addr == 4'h4 |=>
    cfg.modem_control[3:2] == $past(bus.wdata[3:2]))
    else $error("spare bits not stored");
  pair_sel_a: assert property (
    ctl.flow_pair_dtr == $past(cfg.modem_control[2]))
    else $error("pair select wrong");
  dlab_wr_a: assert property (bus.wr && bus.addr == 4'h0 &&
    cfg.line_control[7] |=> cfg.divisor_low == $past(bus.wdata) &&
    !wcfg.tx_load) else $error("divisor write misrouted");
  loop_a: assert property (ctl.loopback == $past(cfg.modem_control[4]))
    else $error("loopback wrong");
  auto_flow_a: assert property ({ctl.auto_cts, ctl.auto_rts} ==
    $past(cfg.enhanced_function[7:6])) else $error("auto flow wrong");
  dir_pol_a: assert property (
    ctl.dir_active_low == $past(cfg.divisor_fraction_modes[7]))
    else $error("direction polarity wrong");
  shared_wr_a: assert property (bus.wr && bus.addr == 4'h0 &&
    !cfg.line_control[7] |=> wcfg.tx_load && $stable(cfg.divisor_low) &&
    wcfg.tx_holding == $past(bus.wdata)) else $error("shared write wrong");
endmodule
